// File: hdl/krc_top.sv
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps

// Operation
// - soft reset writes take effect only while the unlock code equals 1010b
// - the unlock key survives the soft device reset it enables
// - an enabled write of 1 to reset bit 0 resets the whole device
// - writing 1 to calibration bit 0 starts the offset calibration cycle; the code drops such a write while the soft device reset is held
// - unlock key bits 7 to 4 read zero; host never writes them
// - bits 7 to 1 of reset and calibration registers read zero
module krc_top
	import krc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              hsel_i,
	input  wire logic [ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [DATA_W-1:0] hwdata_i,
	input  wire logic              hready_i,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	output logic [DATA_W-1:0]      hrdata_o,
	output logic                   dev_reset_n_o,
	output logic                   cal_start_o
);

	krc_bus_state_e        state_q;
	krc_bus_state_e        state_d;
	krc_addr_phase_s       aph_q;
	krc_addr_phase_s       aph_d;
	logic [CODE_W-1:0]     unlock_code_q;
	logic                  cal_seen_q;
	logic                  addr_take;
	logic                  wr_en;
	logic                  rd_en;
	logic                  wr_key;
	logic                  wr_rst;
	logic                  wr_cal;
	logic                  rst_bit;
	logic                  cal_bit;
	logic                  soft_reset_req;
	logic                  cal_req;
	logic                  rst_busy;
	logic                  code_match;
	logic [DATA_W-1:0]     rdata_d;

	// an address phase is taken when selected, active and the bus is ready
	assign addr_take = hsel_i && hready_i &&
		((htrans_i == HTRANS_NONSEQ) || (htrans_i == HTRANS_SEQ));

	// decode of the address phase into the held struct
	always_comb begin
		aph_d       = aph_q;
		aph_d.hit   = 1'b0;
		if (addr_take) begin
			aph_d.hit   = 1'b1;
			aph_d.write = hwrite_i;
			aph_d.idx   = haddr_i[IDX_LSB +: IDX_W];
		end
	end

	// two-state slave: every transfer gets one wait cycle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			KRC_IDLE: begin
				if (addr_take) begin
					state_d = KRC_WAIT;
				end
			end
			KRC_WAIT: begin
				state_d = KRC_IDLE;
			end
			default: begin
				state_d = KRC_IDLE;
			end
		endcase
	end

	// bus state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= KRC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// held address phase
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aph_q <= '0;
		end else if (state_q == KRC_IDLE) begin
			aph_q <= aph_d;
		end
	end

	// hwdata is valid in the wait cycle of a write data phase
	assign wr_en = (state_q == KRC_WAIT) && aph_q.hit && aph_q.write;
	assign rd_en = (state_q == KRC_WAIT) && aph_q.hit && !aph_q.write;

	// per-register write strobes of the data phase
	assign wr_key = wr_en && (aph_q.idx == IDX_RESET_UNLOCK);
	assign wr_rst = wr_en && (aph_q.idx == IDX_SOFT_RESET_CONTROL);
	assign wr_cal = wr_en && (aph_q.idx == IDX_ZERO_ERROR_CAL);

	// write-only pulse bits taken straight from the data bus
	assign rst_bit = hwdata_i[SOFT_RESET_BIT];
	assign cal_bit = hwdata_i[CAL_TRIGGER_BIT];

	// unlock comparison against the key field
	assign code_match = (unlock_code_q == UNLOCK_CODE_VAL);

	// reset request only when unlocked and not already in reset
	assign soft_reset_req = wr_rst && rst_bit && code_match && !rst_busy;

	// calibration request, held off while the device sits in reset
	assign cal_req = wr_cal && cal_bit && !rst_busy;

	// unlock key: only power-up or a key write of zero clears it, the soft reset does not
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unlock_code_q <= UNLOCK_RESET_VAL;
		end else if (wr_key) begin
			unlock_code_q <= hwdata_i[CODE_W-1:0];
		end
	end

	// reset stretcher driving the device reset output
	krc_reset_gen u_reset_gen (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n_i),
		.req_i         (soft_reset_req),
		.dev_reset_n_o (dev_reset_n_o),
		.busy_o        (rst_busy)
	);

	// calibration start pulse, high for the one cycle after each calibration request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_start_o <= 1'b0;
		end else begin
			cal_start_o <= cal_req;
		end
	end

	// sticky record of a launched calibration, cleared by any device reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_seen_q <= 1'b0;
		end else if (cal_req) begin
			cal_seen_q <= 1'b1;
		end else if (rst_busy) begin
			cal_seen_q <= 1'b0;
		end
	end

	// read mux; pulse registers and reserved bits read zero
	always_comb begin
		rdata_d = RDATA_ZERO;
		unique case (aph_q.idx)
			IDX_SOFT_RESET_CONTROL: rdata_d = RDATA_ZERO;
			IDX_ZERO_ERROR_CAL:     rdata_d = RDATA_ZERO;
			IDX_RESET_UNLOCK: begin
				rdata_d[CODE_W-1:0] = unlock_code_q;
			end
			IDX_KRC_STATUS: begin
				rdata_d[STAT_UNLOCKED_BIT] = code_match;
				rdata_d[STAT_RST_BUSY_BIT] = rst_busy;
				rdata_d[STAT_CAL_SEEN_BIT] = cal_seen_q;
			end
			default: rdata_d = RDATA_ZERO;
		endcase
	end

	// read data register, loaded at the end of the wait cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_o <= RDATA_ZERO;
		end else if (rd_en) begin
			hrdata_o <= rdata_d;
		end
	end

	// ready drops for one cycle after each taken address phase
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hreadyout_o <= 1'b1;
		end else begin
			hreadyout_o <= !(state_d == KRC_WAIT);
		end
	end

	// response is always okay
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hresp_o <= HRESP_OKAY;
		end else begin
			hresp_o <= HRESP_OKAY;
		end
	end

endmodule // krc_top

// File: hdl/krc_pkg.sv
package krc_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W  = 8;

	// register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SOFT_RESET_CONTROL = 8'h14;
	localparam logic [IDX_W-1:0] IDX_ZERO_ERROR_CAL     = 8'h15;
	localparam logic [IDX_W-1:0] IDX_RESET_UNLOCK       = 8'h17;
	localparam logic [IDX_W-1:0] IDX_KRC_STATUS         = 8'h18;

	// byte address field: word index sits above the two byte-lane bits
	localparam int unsigned IDX_LSB = 2;

	// field layouts
	localparam int unsigned CODE_W            = 4;
	localparam int unsigned SOFT_RESET_BIT    = 0;
	localparam int unsigned CAL_TRIGGER_BIT   = 0;
	localparam int unsigned STAT_UNLOCKED_BIT = 0;
	localparam int unsigned STAT_RST_BUSY_BIT = 1;
	localparam int unsigned STAT_CAL_SEEN_BIT = 2;

	// values
	localparam logic [CODE_W-1:0] UNLOCK_CODE_VAL  = 4'hA;
	localparam logic [CODE_W-1:0] UNLOCK_RESET_VAL = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_ZERO       = 32'h0000_0000;

	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'h0;

	// timing
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned SOFT_RST_TIME_NS  = 100;
	localparam int unsigned SOFT_RST_CYCLES   =
		(SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_CNT_W         = 8;

	// latched address phase
	typedef struct packed {
		logic             write;
		logic [IDX_W-1:0] idx;
		logic             hit;
	} krc_addr_phase_s;

	// bus slave states
	typedef enum logic [1:0] {
		KRC_IDLE = 2'b01,
		KRC_WAIT = 2'b10
	} krc_bus_state_e;

endpackage : krc_pkg

// File: hdl/krc_reset_gen.sv
`timescale 1ns/1ps

// stretches a one-cycle soft reset request into a held device reset
module krc_reset_gen
	import krc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic req_i,
	output logic      dev_reset_n_o,
	output logic      busy_o
);

	logic [RST_CNT_W-1:0] cnt_q;
	localparam logic [RST_CNT_W-1:0] CNT_LOAD = RST_CNT_W'(SOFT_RST_CYCLES);
	localparam logic [RST_CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [RST_CNT_W-1:0] CNT_ONE  = RST_CNT_W'(1);

	// hold counter, reloaded by each request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= CNT_ZERO;
		end else if (req_i) begin
			cnt_q <= CNT_LOAD;
		end else if (cnt_q != CNT_ZERO) begin
			cnt_q <= cnt_q - CNT_ONE;
		end
	end

	// registered reset output, low while the counter runs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dev_reset_n_o <= 1'b0;
			busy_o        <= 1'b0;
		end else begin
			dev_reset_n_o <= !(req_i || (cnt_q > CNT_ONE));
			busy_o        <= req_i || (cnt_q > CNT_ONE);
		end
	end

endmodule // krc_reset_gen

// File: verif/krc_checker.sv
`timescale 1ns/1ps

// watches the bus and the pulse outputs of the block
module krc_checker
	import krc_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0]        htrans_i,
	input wire logic              hwrite_i,
	input wire logic [DATA_W-1:0] hwdata_i,
	input wire logic              hready_i,
	input wire logic [DATA_W-1:0] hrdata_o,
	input wire logic              dev_reset_n_o,
	input wire logic              cal_start_o
);
	// taken address phases sorted by register
	wire logic       tk     = hsel_i & hready_i & htrans_i[1];
	wire logic [7:0] ix     = haddr_i[9:2];
	wire logic       rd     = tk & ~hwrite_i;
	wire logic       cal_wr = tk & hwrite_i & (ix == IDX_ZERO_ERROR_CAL);
	wire logic       rst_wr = tk & hwrite_i & (ix == IDX_SOFT_RESET_CONTROL);

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	cal_pulse_a: assert property (cal_start_o |=> !cal_start_o)
		else $error("calibration pulse longer than one cycle");
	cal_cause_a: assert property ($rose(cal_start_o) |-> $past(cal_wr, 2) && $past(hwdata_i[0]))
		else $error("calibration start without a write of one");
	rst_cause_a: assert property ($fell(dev_reset_n_o) |-> $past(rst_wr, 2) && $past(hwdata_i[0]))
		else $error("device reset without a reset write");
	rst_len_a: assert property ($fell(dev_reset_n_o) |-> ##9 !dev_reset_n_o ##1 dev_reset_n_o)
		else $error("device reset length wrong");
	rst_read_a: assert property (rd && ix == IDX_SOFT_RESET_CONTROL |-> ##2 hrdata_o == RDATA_ZERO)
		else $error("reset register read not zero");
	cal_read_a: assert property (rd && ix == IDX_ZERO_ERROR_CAL |-> ##2 hrdata_o == RDATA_ZERO)
		else $error("calibration register read not zero");
	key_read_a: assert property (rd && ix == IDX_RESET_UNLOCK |-> ##2 hrdata_o[7:4] == 4'h0)
		else $error("unlock key upper bits not zero");
endmodule // krc_checker

bind krc_top krc_checker krc_checker_inst (.clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
	.hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .dev_reset_n_o, .cal_start_o);

// File: verif/krc_host.sv
`timescale 1ns/1ps

// bus master in the place of the host controller
module krc_host
	import krc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              hready_i,
	input  wire logic [DATA_W-1:0] hrdata_i,
	output logic                   hsel_o,
	output logic [ADDR_W-1:0]      haddr_o,
	output logic [1:0]             htrans_o,
	output logic                   hwrite_o,
	output logic [DATA_W-1:0]      hwdata_o
);
	// idle bus at time zero
	initial begin
		hsel_o = 1'h0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'h0;
		hwdata_o = 32'h0;
	end

	// one single word transfer; released lines toggle
	task automatic xfer(input logic w, input logic [IDX_W-1:0] ix, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		hsel_o <= 1'h1;
		htrans_o <= HTRANS_NONSEQ;
		hwrite_o <= w;
		haddr_o <= {22'h0, ix, 2'h0};
		@(posedge clk_i);
		while (!hready_i) @(posedge clk_i);
		hsel_o <= 1'h0;
		htrans_o <= 2'h0;
		hwdata_o <= w ? d : ~hwdata_o;
		haddr_o <= ~haddr_o;
		@(posedge clk_i);
		while (!hready_i) @(posedge clk_i);
		q = hrdata_i;
		hwdata_o <= ~hwdata_o;
	endtask

	// clears the key so a stray write cannot reset
	task automatic lock;
		logic [DATA_W-1:0] q;
		xfer(1'h1, IDX_RESET_UNLOCK, 32'h0, q);
	endtask
endmodule // krc_host

// File: verif/tb.sv
`timescale 1ns/1ps

module tb;
	import krc_pkg::*;
	logic        clk_i   = 1'h0;
	logic        rst_n_i = 1'h0;
	logic        hsel, hwrite, hready, hresp, dev_reset_n, cal, b;
	logic        cs = 1'h0;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [31:0] r = 32'h2FD7;
	logic [3:0]  k;
	int          failures = 0;
	int          total_checks = 0;
	int          cal_n = 0;
	int          low_n = 0;
	int          n;

	always #5 clk_i = ~clk_i;

	krc_top krc_top_inst (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .dev_reset_n_o(dev_reset_n),
		.cal_start_o(cal));
	krc_host krc_host_inst (.clk_i, .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));

	// counts pulse and reset cycles
	always @(posedge clk_i) begin
		cal_n += int'(cal === 1'h1);
		low_n += int'(dev_reset_n === 1'h0);
	end

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function int exp_low(input logic [3:0] c, input logic w);
		return (c == UNLOCK_CODE_VAL && w) ? SOFT_RST_CYCLES : 0;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog
	initial begin
		#100000;
		failures++;
		test_done;
	end

	// keyed reset and calibration with random data
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		krc_host_inst.xfer(1'h0, IDX_RESET_UNLOCK, 32'h0, q);
		chk(q, 32'h0);
		krc_host_inst.xfer(1'h0, 8'h30, 32'h0, q);
		chk(q, RDATA_ZERO);
		for (int i = 0; i < 12; i++) begin
			r = lfsr(r);
			k = (i < 3) ? UNLOCK_CODE_VAL : r[3:0];
			b = (i == 0) | r[4];
			n = low_n;
			krc_host_inst.xfer(1'h1, IDX_RESET_UNLOCK, {28'h0, k}, q);
			krc_host_inst.xfer(1'h1, IDX_SOFT_RESET_CONTROL, {r[31:1], b}, q);
			repeat (14) @(posedge clk_i);
			chk(low_n - n, exp_low(k, b));
			cs = cs & (exp_low(k, b) == 0);
			krc_host_inst.xfer(1'h0, IDX_KRC_STATUS, 32'h0, q);
			chk(q, {29'h0, cs, 1'h0, k == UNLOCK_CODE_VAL});
			krc_host_inst.xfer(1'h0, IDX_RESET_UNLOCK, 32'h0, q);
			chk(q, {28'h0, k});
			krc_host_inst.xfer(1'h0, IDX_SOFT_RESET_CONTROL, 32'h0, q);
			chk(q, 32'h0);
			chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
			b = (i == 1) | r[5];
			n = cal_n;
			krc_host_inst.xfer(1'h1, IDX_ZERO_ERROR_CAL, {r[31:6], 5'h0, b}, q);
			repeat (3) @(posedge clk_i);
			chk(cal_n - n, {31'h0, b});
			cs = cs | b;
			krc_host_inst.xfer(1'h0, IDX_ZERO_ERROR_CAL, 32'h0, q);
			chk(q, 32'h0);
			krc_host_inst.lock;
			$display("test %0d done", i);
		end
		test_done;
	end
endmodule // tb
